// File: hdl/port_alt_pkg.sv
package port_alt_pkg;

   // Pin counts of the ports handled here.
   localparam int P5_PINS = 6;
   localparam int P6_PINS = 9;
   localparam int P7_PINS = 16;
   localparam int P9_PINS = 16;

   // Reset values of the mode and select bits.
   localparam logic [15:0] DIR_RESET = 16'hffff;
   localparam logic [15:0] SEL_RESET = 16'h0000;

   // Function codes for one pin: extended select (bit 1), select (bit 0).
   localparam logic [1:0] SEL_PORT = 2'h0;
   localparam logic [1:0] SEL_FC = 2'h1;
   localparam logic [1:0] SEL_FCE = 2'h2;
   localparam logic [1:0] SEL_BOTH = 2'h3;

   // Port 9 pin positions.
   localparam int P9_KEY6_TX = 0;
   localparam int P9_KEY7_RX = 1;
   localparam int P9_TQ_LO = 2;
   localparam int P9_TQ_HI = 5;
   localparam int P9_TP_LO = 6;
   localparam int P9_TP_HI = 7;
   localparam int P9_SO = 8;
   localparam int P9_SCK = 9;
   localparam int P9_INT4 = 13;
   localparam int P9_INT5 = 14;
   localparam int P9_INT6 = 15;

   typedef enum logic [2:0] {
      FN_PORT = 3'b000,
      FN_ALT_A = 3'b001,
      FN_ALT_B = 3'b010,
      FN_ALT_C = 3'b011,
      FN_UNDEF = 3'b100
   } pin_fn_t;

   // Software-written configuration of one port.
   typedef struct packed {
      logic [15:0] ctrl_mode;
      logic [15:0] func_sel;
      logic [15:0] func_sel_ext;
   } port_cfg_t;

   // Per-pin output view: level and output enable.
   typedef struct packed {
      logic [15:0] level;
      logic [15:0] oe;
   } pin_drive_t;

endpackage

// File: hdl/pin_fn_decode.sv
`timescale 1ns/1ns
// Decodes one pin's control-mode and select bits to a function class.
module pin_fn_decode
   import port_alt_pkg::*;
(
   input wire logic i_ctrl_mode,
   input wire logic i_func_sel,
   input wire logic i_func_sel_ext,
   input wire logic i_has_ext,
   output pin_fn_t o_fn
);
   logic [1:0] code;

   always_comb begin
      code = {i_func_sel_ext & i_has_ext, i_func_sel};
      if (!i_ctrl_mode) begin
         o_fn = FN_PORT;
      end else begin
         case (code)
            SEL_FC: o_fn = FN_ALT_A;
            SEL_FCE: o_fn = FN_ALT_B;
            SEL_BOTH: o_fn = FN_ALT_C;
            SEL_PORT: o_fn = FN_UNDEF;
            default: o_fn = FN_UNDEF;
         endcase
      end
   end
endmodule

// File: hdl/port_alt_function_select.sv
`timescale 1ns/1ns
// Behaviour
// - Port 6 control mode with select bit at 0 gives undefined output.
// - Port 9 control mode with both selects at 0 gives undefined output.
// - Output latch is ignored while a pin runs an alternate function.
// - Port 7 pin routes to its analog channel when its mode bit is 1.
// - Pin 90: key return 6 on select, UART transmit 1 on extended.
// - Pins 92-95: timer capture on select, compare output on extended.
// - Pins 96-97: timer p2 capture, output; pin 97 also serial in.
// - Pin 913: interrupt 4 on select, clock output on extended.
// - Flash programming mode pin is never touched by port control.
module port_alt_function_select
   import port_alt_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rstn,
   input port_alt_pkg::port_cfg_t i_port6_cfg,
   input port_alt_pkg::port_cfg_t i_port9_cfg,
   input wire logic [15:0] i_port7_dir_bit,
   input wire logic [15:0] i_port9_dir_bit,
   input wire logic [15:0] i_port9_output_latch,
   input wire logic [15:0] i_port9_pin_in,
   input wire logic [15:0] i_port7_pin_in,
   input wire logic i_clock_out_ctrl_mode_bit,
   input wire logic i_system_clock_out,
   input wire logic i_flash_prog_mode_pin,
   input wire logic i_uart_transmit_1,
   input wire logic [3:0] i_timer_q1_compare_out,
   input wire logic [1:0] i_timer_p2_out,
   input wire logic i_serial_out_1,
   input wire logic i_serial_clock_1_out,
   input wire logic i_serial_clock_1_oe,
   input wire logic i_programmable_clock_out,
   output port_alt_pkg::pin_drive_t o_port9_drive,
   output logic o_clock_out_pin,
   output logic o_clock_out_oe,
   output logic [15:0] o_analog_input_channel,
   output logic o_key_return_in_6,
   output logic o_key_return_in_7,
   output logic o_uart_receive_1,
   output logic [3:0] o_timer_q1_capture_in,
   output logic [1:0] o_timer_p2_capture_in,
   output logic o_serial_in_1,
   output logic o_serial_clock_1_in,
   output logic o_ext_interrupt_in_4,
   output logic o_ext_interrupt_in_5,
   output logic o_ext_interrupt_in_6,
   output logic o_flash_prog_mode,
   output logic [15:0] o_port9_undefined,
   output logic [8:0] o_port6_undefined
);
   import port_alt_pkg::*;

   // ---------------------------------------------------------------
   // Per-pin decode of port 9.
   // ---------------------------------------------------------------
   pin_fn_t fn9 [P9_PINS];
   logic [15:0] has_ext9;
   logic [15:0] lvl_d;
   logic [15:0] oe_d;
   logic [15:0] undef9_d;

   // Pins 98, 99, 914 and 915 have no extended select bit.
   assign has_ext9 = 16'h3cff;

   genvar g;
   generate
      for (g = 0; g < P9_PINS; g++) begin : g_p9
         pin_fn_decode u_dec (
            .i_ctrl_mode(i_port9_cfg.ctrl_mode[g]),
            .i_func_sel(i_port9_cfg.func_sel[g]),
            .i_func_sel_ext(i_port9_cfg.func_sel_ext[g]),
            .i_has_ext(has_ext9[g]),
            .o_fn(fn9[g])
         );
      end
   endgenerate

   // ---------------------------------------------------------------
   // Output side of port 9.
   // ---------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < P9_PINS; i++) begin
         // Port mode drives the latch, the direction bit gates it.
         lvl_d[i] = i_port9_output_latch[i];
         oe_d[i] = ~i_port9_dir_bit[i];
         undef9_d[i] = (fn9[i] == FN_UNDEF);
         if (fn9[i] != FN_PORT) begin
            // The latch is dropped once an alternate function owns the pin.
            lvl_d[i] = 1'b0;
            oe_d[i] = 1'b0;
         end
      end
      if (fn9[P9_KEY6_TX] == FN_ALT_B) begin
         lvl_d[P9_KEY6_TX] = i_uart_transmit_1;
         oe_d[P9_KEY6_TX] = 1'b1;
      end
      for (int i = P9_TQ_LO; i <= P9_TQ_HI; i++) begin
         if (fn9[i] == FN_ALT_B) begin
            lvl_d[i] = i_timer_q1_compare_out[i - P9_TQ_LO];
            oe_d[i] = 1'b1;
         end
      end
      for (int i = P9_TP_LO; i <= P9_TP_HI; i++) begin
         if (fn9[i] == FN_ALT_C) begin
            lvl_d[i] = i_timer_p2_out[i - P9_TP_LO];
            oe_d[i] = 1'b1;
         end
      end
      if (fn9[P9_SO] == FN_ALT_A) begin
         lvl_d[P9_SO] = i_serial_out_1;
         oe_d[P9_SO] = 1'b1;
      end
      if (fn9[P9_SCK] == FN_ALT_A) begin
         lvl_d[P9_SCK] = i_serial_clock_1_out;
         oe_d[P9_SCK] = i_serial_clock_1_oe;
      end
      if (fn9[P9_INT4] == FN_ALT_B) begin
         lvl_d[P9_INT4] = i_programmable_clock_out;
         oe_d[P9_INT4] = 1'b1;
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_rstn) begin
         o_port9_drive <= '0;
         o_port9_undefined <= SEL_RESET;
      end else begin
         o_port9_drive.level <= lvl_d;
         o_port9_drive.oe <= oe_d;
         o_port9_undefined <= undef9_d;
      end
   end

   // ---------------------------------------------------------------
   // Input routing of port 9 to the peripherals.
   // ---------------------------------------------------------------
   always_ff @(posedge i_clock) begin
      if (!i_rstn) begin
         o_key_return_in_6 <= 1'b0;
         o_key_return_in_7 <= 1'b0;
         o_uart_receive_1 <= 1'b1;
         o_timer_q1_capture_in <= 4'h0;
         o_timer_p2_capture_in <= 2'h0;
         o_serial_in_1 <= 1'b0;
         o_serial_clock_1_in <= 1'b0;
         o_ext_interrupt_in_4 <= 1'b0;
         o_ext_interrupt_in_5 <= 1'b0;
         o_ext_interrupt_in_6 <= 1'b0;
      end else begin
         o_key_return_in_6 <= (fn9[P9_KEY6_TX] == FN_ALT_A) &
            i_port9_pin_in[P9_KEY6_TX];
         // Both select codes reach key return 7; software gates detection.
         o_key_return_in_7 <= ((fn9[P9_KEY7_RX] == FN_ALT_A) |
            (fn9[P9_KEY7_RX] == FN_ALT_B)) &
            i_port9_pin_in[P9_KEY7_RX];
         o_uart_receive_1 <= (fn9[P9_KEY7_RX] == FN_ALT_B) ?
            i_port9_pin_in[P9_KEY7_RX] : 1'b1;
         for (int i = P9_TQ_LO; i <= P9_TQ_HI; i++) begin
            o_timer_q1_capture_in[i - P9_TQ_LO] <= (fn9[i] == FN_ALT_A) &
               i_port9_pin_in[i];
         end
         for (int i = P9_TP_LO; i <= P9_TP_HI; i++) begin
            o_timer_p2_capture_in[i - P9_TP_LO] <= (fn9[i] == FN_ALT_B) &
               i_port9_pin_in[i];
         end
         o_serial_in_1 <= (fn9[P9_TP_HI] == FN_ALT_A) &
            i_port9_pin_in[P9_TP_HI];
         o_serial_clock_1_in <= (fn9[P9_SCK] == FN_ALT_A) &
            i_port9_pin_in[P9_SCK];
         o_ext_interrupt_in_4 <= (fn9[P9_INT4] == FN_ALT_A) &
            i_port9_pin_in[P9_INT4];
         o_ext_interrupt_in_5 <= (fn9[P9_INT5] == FN_ALT_A) &
            i_port9_pin_in[P9_INT5];
         o_ext_interrupt_in_6 <= (fn9[P9_INT6] == FN_ALT_A) &
            i_port9_pin_in[P9_INT6];
      end
   end

   // ---------------------------------------------------------------
   // Port 7 analog routing, port 6 flag, clock out and flash pin.
   // ---------------------------------------------------------------
   always_ff @(posedge i_clock) begin
      if (!i_rstn) begin
         o_analog_input_channel <= 16'h0000;
         o_port6_undefined <= 9'h000;
         o_clock_out_pin <= 1'b0;
         o_clock_out_oe <= 1'b0;
         o_flash_prog_mode <= 1'b0;
      end else begin
         o_analog_input_channel <= i_port7_dir_bit & i_port7_pin_in;
         o_port6_undefined <= i_port6_cfg.ctrl_mode[8:0] &
            ~i_port6_cfg.func_sel[8:0];
         o_clock_out_pin <= i_clock_out_ctrl_mode_bit &
            i_system_clock_out;
         o_clock_out_oe <= i_clock_out_ctrl_mode_bit;
         // No port control bit reaches this path.
         o_flash_prog_mode <= i_flash_prog_mode_pin;
      end
   end

   // ---------------------------------------------------------------
   // Checks.
   // ---------------------------------------------------------------
   sequence s_tx_sel;
      i_port9_cfg.ctrl_mode[0] && !i_port9_cfg.func_sel[0] &&
         i_port9_cfg.func_sel_ext[0];
   endsequence

   a_uart_tx_route: assert property (@(posedge i_clock) disable iff (!i_rstn)
      s_tx_sel |=> o_port9_drive.oe[0] &&
         o_port9_drive.level[0] == $past(i_uart_transmit_1))
      else $error("pin 90 not carrying uart transmit");

   a_p9_undef_flag: assert property (@(posedge i_clock) disable iff (!i_rstn)
      (i_port9_cfg.ctrl_mode[2] && !i_port9_cfg.func_sel[2] &&
         !i_port9_cfg.func_sel_ext[2]) |=> o_port9_undefined[2])
      else $error("pin 92 undefined state not flagged");

   a_latch_ignored: assert property (@(posedge i_clock) disable iff (!i_rstn)
      (i_port9_cfg.ctrl_mode[3] && i_port9_cfg.func_sel[3]) |=>
         !o_port9_drive.oe[3])
      else $error("latch driven on alternate pin 93");

   a_port_mode: assert property (@(posedge i_clock) disable iff (!i_rstn)
      !i_port9_cfg.ctrl_mode[4] |=>
         o_port9_drive.level[4] == $past(i_port9_output_latch[4]))
      else $error("pin 94 not in port mode");

   a_capture_route: assert property (@(posedge i_clock) disable iff (!i_rstn)
      (i_port9_cfg.ctrl_mode[5] && i_port9_cfg.func_sel[5] &&
         !i_port9_cfg.func_sel_ext[5]) |=>
         o_timer_q1_capture_in[3] == $past(i_port9_pin_in[5]))
      else $error("pin 95 capture not routed");

   a_analog_route: assert property (@(posedge i_clock) disable iff (!i_rstn)
      i_port7_dir_bit[7] |=>
         o_analog_input_channel[7] == $past(i_port7_pin_in[7]))
      else $error("analog channel 7 not routed");

   a_p6_undef_flag: assert property (@(posedge i_clock) disable iff (!i_rstn)
      (i_port6_cfg.ctrl_mode[8] && !i_port6_cfg.func_sel[8]) |=>
         o_port6_undefined[8])
      else $error("port 6 pin 8 undefined not flagged");

   a_pclk_route: assert property (@(posedge i_clock) disable iff (!i_rstn)
      (i_port9_cfg.ctrl_mode[13] && !i_port9_cfg.func_sel[13] &&
         i_port9_cfg.func_sel_ext[13]) |=>
         o_port9_drive.oe[13] && !o_ext_interrupt_in_4)
      else $error("pin 913 clock output not selected");

   a_flash_pin: assert property (@(posedge i_clock) disable iff (!i_rstn)
      1'b1 |=> o_flash_prog_mode == $past(i_flash_prog_mode_pin))
      else $error("flash mode pin not passed through");

   a_p2_out: assert property (@(posedge i_clock) disable iff (!i_rstn)
      (i_port9_cfg.ctrl_mode[7] && i_port9_cfg.func_sel[7] &&
         i_port9_cfg.func_sel_ext[7]) |=> o_port9_drive.oe[7])
      else $error("pin 97 timer output not driven");

endmodule

// File: testbench/port_alt_function_select_tb.sv
`timescale 1ns/1ns
module port_alt_function_select_tb;
   import port_alt_pkg::*;
   // ------------------------------------------------------------
   // Stimulus and expected-result model.
   // ------------------------------------------------------------
   localparam logic [15:0] NO_EXT = 16'hc300;
   localparam logic [15:0] NO_BOTH = 16'h203f;
   logic i_clock = 1'b0;
   logic i_rstn = 1'b0;
   port_cfg_t p6 = '0;
   port_cfg_t p9 = '0;
   logic [15:0] dir7 = '1, dir9 = '1, lat9 = '0, pin9 = '0, pin7 = '0;
   logic flash = 0, tx = 0, so = 0, scko = 0, sckoe = 0, pck = 0;
   logic clk_ctl = 0, sysclk = 0;
   logic [3:0] q1o = '0;
   logic [1:0] p2o = '0;
   logic [31:0] seed = 32'h5ebfd015;
   logic [89:0] exp_q[$];
   pin_drive_t drv;
   logic [15:0] an, und9;
   logic [8:0] und6;
   logic [3:0] q1c;
   logic [1:0] p2c;
   logic rx, k6, k7, si, sck, i4, i5, i6, cpin, coe, fl;
   int errors = 0;
   int checks = 0;

   always #2 i_clock = ~i_clock;

   port_alt_function_select uut (.i_clock(i_clock), .i_rstn(i_rstn),
      .i_port6_cfg(p6), .i_port9_cfg(p9), .i_port7_dir_bit(dir7),
      .i_port9_dir_bit(dir9), .i_port9_output_latch(lat9),
      .i_port9_pin_in(pin9), .i_port7_pin_in(pin7),
      .i_clock_out_ctrl_mode_bit(clk_ctl), .i_system_clock_out(sysclk),
      .i_flash_prog_mode_pin(flash), .i_uart_transmit_1(tx),
      .i_timer_q1_compare_out(q1o), .i_timer_p2_out(p2o),
      .i_serial_out_1(so), .i_serial_clock_1_out(scko),
      .i_serial_clock_1_oe(sckoe), .i_programmable_clock_out(pck),
      .o_port9_drive(drv), .o_clock_out_pin(cpin), .o_clock_out_oe(coe),
      .o_analog_input_channel(an), .o_key_return_in_6(k6),
      .o_key_return_in_7(k7), .o_uart_receive_1(rx),
      .o_timer_q1_capture_in(q1c), .o_timer_p2_capture_in(p2c),
      .o_serial_in_1(si), .o_serial_clock_1_in(sck),
      .o_ext_interrupt_in_4(i4), .o_ext_interrupt_in_5(i5),
      .o_ext_interrupt_in_6(i6), .o_flash_prog_mode(fl),
      .o_port9_undefined(und9), .o_port6_undefined(und6));

   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function logic [89:0] model();
      logic [15:0] c, a, b, d, oe, lv, und;
      c = p9.ctrl_mode;
      a = c & p9.func_sel & ~(p9.func_sel_ext & ~NO_EXT);
      b = c & ~p9.func_sel & p9.func_sel_ext & ~NO_EXT;
      d = c & p9.func_sel & p9.func_sel_ext & ~NO_EXT;
      und = c & ~p9.func_sel & ~(p9.func_sel_ext & ~NO_EXT);
      oe = ~dir9 & ~c;
      lv = lat9;
      if (b[0]) {oe[0], lv[0]} = {1'b1, tx};
      for (int k = 0; k < 4; k++)
         if (b[k+2]) {oe[k+2], lv[k+2]} = {1'b1, q1o[k]};
      for (int k = 0; k < 2; k++)
         if (d[k+6]) {oe[k+6], lv[k+6]} = {1'b1, p2o[k]};
      if (a[8]) {oe[8], lv[8]} = {1'b1, so};
      if (a[9]) {oe[9], lv[9]} = {sckoe, scko};
      if (b[13]) {oe[13], lv[13]} = {1'b1, pck};
      if (!i_rstn) return 90'h1 << 16;
      return {lv & oe, oe, dir7 & pin7, und,
         p6.ctrl_mode[8:0] & ~p6.func_sel[8:0], b[1] ? pin9[1] : 1'b1,
         a[0] & pin9[0], (a[1] | b[1]) & pin9[1], a[5:2] & pin9[5:2],
         b[7:6] & pin9[7:6], a[7] & pin9[7], a[9] & pin9[9],
         a[13] & pin9[13], a[14] & pin9[14], a[15] & pin9[15],
         clk_ctl & sysclk, clk_ctl, flash};
   endfunction

   task rnd_io();
      logic [31:0] r;
      r = rnd();
      {flash, tx, q1o, p2o, so, scko, sckoe, pck, clk_ctl, sysclk} = r[13:0];
      {dir7, dir9} = rnd();
      {lat9, pin9} = rnd();
      r = rnd();
      pin7 = r[15:0];
   endtask

   task rnd_cfg();
      logic [63:0] w;
      w = {rnd(), rnd()};
      p6 = w[47:0];
      w = {rnd(), rnd()};
      p9 = w[47:0];
      p9.func_sel_ext &= ~(p9.func_sel & NO_BOTH);
      p9.ctrl_mode &= ~16'h1c00;
      if (p9.func_sel[6] & ~p9.func_sel_ext[6]) p9.ctrl_mode[6] = 1'b0;
   endtask

   task apply();
      rnd_io();
      exp_q.push_back(model());
      @(negedge i_clock);
   endtask

   task compare_res(input logic [89:0] e, input logic [89:0] g);
      checks++;
      if (g !== e) begin
         errors++;
         $display("Error at %0t: outputs %h, expected %h", $time, g, e);
      end
   endtask

   task results();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Output watcher and main sequence.
   // ------------------------------------------------------------
   always @(posedge i_clock) begin
      #1;
      if (exp_q.size() > 0)
         compare_res(exp_q.pop_front(), {drv.level & drv.oe, drv.oe, an,
            und9, und6, rx, k6, k7, q1c, p2c, si, sck, i4, i5, i6, cpin,
            coe, fl});
   end

   initial begin
      @(negedge i_clock);
      repeat (16) apply();
      i_rstn = 1'b1;
      for (int n = 0; n < 16; n++)
         for (int k = 1; k < 4; k++) begin
            if ((n > 9 && n < 13) || (k == 3 && NO_BOTH[n]) ||
                  (k == 1 && n == 6)) continue;
            p9 = '0;
            p9.func_sel[n] = k[0];
            p9.func_sel_ext[n] = k[1];
            apply();
            p9.ctrl_mode[n] = 1'b1;
            apply();
            apply();
         end
      p9 = '0;
      p6.func_sel = 16'h00a5;
      apply();
      p9.ctrl_mode = 16'he3ff;
      p6.ctrl_mode = 16'h01ff;
      apply();
      for (int i = 0; i < 400; i++) begin
         rnd_cfg();
         i_rstn = (i % 97) > 2;
         apply();
      end
      for (int i = 0; i < 4 && exp_q.size() > 0; i++) @(negedge i_clock);
      if (exp_q.size() > 0) begin
         errors++;
         $display("Error at %0t: outputs never settled", $time);
      end
      results();
   end
endmodule
